/* shared/gpio_exp_cfg.svh */
`ifndef GPIO_EXP_CFG_SVH
`define GPIO_EXP_CFG_SVH

// Command pointer values, low three bits only
`define REG_LEVEL0   3'h0
`define REG_LEVEL1   3'h1
`define REG_LATCH0   3'h2
`define REG_LATCH1   3'h3
`define REG_INVERT0  3'h4
`define REG_INVERT1  3'h5
`define REG_DIR0     3'h6
`define REG_DIR1     3'h7

// Pair select field of the pointer
`define PAIR_LEVEL   2'h0
`define PAIR_LATCH   2'h1
`define PAIR_INVERT  2'h2
`define PAIR_DIR     2'h3

// Reset values
`define LATCH_RST    8'hFF
`define INVERT_RST   8'h00
`define DIR_RST      8'hFF
`define PTR_RST      8'h00

// Frame constants
`define BYTE_BITS    4'h8
`define LAST_RD_BIT  4'h7
`define RW_READ      1'b1

`endif

/* shared/gpio_exp_pkg.sv */
package gpio_exp_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_MACK
   } busState_t;

   typedef logic [1:0][7:0] portPair_t;

endpackage : gpio_exp_pkg

/* rtl/sync_2ff.sv */
module sync_2ff #(
   parameter int                WIDTH   = 1,
   parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
   input  wire logic             clk,    // System clock
   input  wire logic             rst_b,  // Async reset
   input  wire logic [WIDTH-1:0] din,    // Asynchronous inputs
   output logic      [WIDTH-1:0] dout    // Synchronised outputs
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= RST_VAL;
         dout   <= RST_VAL;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule : sync_2ff

/* rtl/port_alert.sv */
module port_alert #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,      // System clock
   input  wire logic             rst_b,    // Async reset
   input  wire logic [WIDTH-1:0] level,    // Synchronised raw pin levels
   input  wire logic [WIDTH-1:0] isInput,  // Direction bits, 1 = input
   input  wire logic             readClr,  // Port read acknowledged
   output logic                  alert     // Level change pending
);

   logic [WIDTH-1:0] ref_q;
   logic [1:0]       settle_q;
   logic             primed;

   // The pin synchroniser still shows its reset value for two clocks after release
   assign primed = (settle_q == 2'h3);

   // Reference follows the pins until they have settled, so reset raises no alert
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_q    <= '0;
         settle_q <= 2'h0;
      end else begin
         if (!primed) begin
            settle_q <= settle_q + 2'h1;
         end
         if (!primed || readClr) begin
            ref_q <= level;
         end
      end
   end

   // Returning to the old level clears it on its own; outputs never alert
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alert <= 1'b0;
      end else begin
         alert <= primed && !readClr && |((level ^ ref_q) & isInput); // see R19
      end
   end

endmodule : port_alert

/* rtl/i2c_gpio_expander.sv */
// Operation
// (R01) Two address straps set the low slave address bits; four devices share a bus.
// (R02) Last address bit: 1 means read, 0 means write.
// (R03) First byte after address is the command, stored in the pointer.
// (R04) The pointer is write only and never returned on a read.
// (R05) Commands 00h/01h select the port A/B pin level registers.
// (R06) Pin level registers report the pin whether input or output.
// (R07) Writes to pin level registers are acknowledged and discarded.
// (R08) Pin level registers follow the pins, no reset value.
// (R09) Commands 02h/03h select drive latches, reset to all ones.
// (R10) A latch bit drives its pin only while the pin is an output.
// (R11) Latch reads return the written value, not the pin.
// (R12) Commands 04h/05h select invert registers, reset to zero.
// (R13) Invert bit 1 on an input pin complements the reported level.
// (R14) Commands 06h/07h select direction registers, reset to all ones.
// (R15) Direction 1 makes a released input, 0 drives from the latch.
// (R16) Only the low three pointer bits select a register.
// (R17) Each written byte toggles pointer bit 0, unlimited bytes.
// (R18) Each read byte comes from the other register of the pair.
// (R19) Input pin edges raise the alert; port read or level return clears it.
// (R20) Reset low holds registers, bus machine and pins at defaults.
`include "gpio_exp_cfg.svh"

module i2c_gpio_expander
   import gpio_exp_pkg::*;
#(
   parameter logic [4:0] ADDR_UPPER = 5'h0A  // Fixed upper address bits, arbitrary
) (
   input  wire logic       clk,            // 50 MHz system clock
   input  wire logic       rst_b,          // Reset pin, active low
   input  wire logic       sclPin,         // Bus clock from the master
   input  wire logic       sdaIn,          // Bus data level
   output logic            sdaOut,         // Bus data drive value
   output logic            sdaOeB,         // Bus data drive enable, low drives
   input  wire logic       addrStrapLow,   // Address strap, bit 0
   input  wire logic       addrStrapHigh,  // Address strap, bit 1
   input  wire logic [7:0] portAIn,        // Port A pin levels
   output logic      [7:0] portAOut,       // Port A drive values
   output logic      [7:0] portAOeB,       // Port A enables, low drives
   input  wire logic [7:0] portBIn,        // Port B pin levels
   output logic      [7:0] portBOut,       // Port B drive values
   output logic      [7:0] portBOeB,       // Port B enables, low drives
   output logic            alertOut,       // Alert drive value
   output logic            alertOeB        // Alert enable, low pulls down
);

   busState_t  state_q;
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic       rw_q;
   logic       sclD_q;
   logic       sdaD_q;
   portPair_t  drvLatch_q;
   portPair_t  invSel_q;
   portPair_t  dir_q;
   portPair_t  pinS;
   portPair_t  pinLevel;
   logic       sclS;
   logic       sdaS;
   logic [1:0] strapS;
   logic       sclRise;
   logic       sclFall;
   logic       startDet;
   logic       stopDet;
   logic       addrMatch;
   logic       byteDone;
   logic       cmdDone;
   logic       wrCommit;
   logic       mackRise;
   logic [1:0] readClr;
   logic [1:0] alerts;

   sync_2ff #(
      .WIDTH   (4),
      .RST_VAL (4'hF)
   ) u_busSync (
      .clk   (clk),
      .rst_b (rst_b),
      .din   ({sclPin, sdaIn, addrStrapHigh, addrStrapLow}),
      .dout  ({sclS, sdaS, strapS})
   );

   sync_2ff #(
      .WIDTH   (16),
      .RST_VAL (16'h0000)
   ) u_pinSync (
      .clk   (clk),
      .rst_b (rst_b),
      .din   ({portBIn, portAIn}),
      .dout  (pinS)
   );

   // Register selected by the pointer, level registers live
   function automatic logic [7:0] readByte(input logic [7:0] ptr);
      logic p;
      p = ptr[0];
      unique case (ptr[2:1]) // see R16
         `PAIR_LEVEL:  readByte = pinLevel[p];   // see R05
         `PAIR_LATCH:  readByte = drvLatch_q[p]; // see R11
         `PAIR_INVERT: readByte = invSel_q[p];
         `PAIR_DIR:    readByte = dir_q[p];
      endcase
   endfunction : readByte

   function automatic logic inPair(input logic [7:0] ptr, input logic [1:0] pair);
      inPair = (ptr[2:1] == pair);
   endfunction : inPair

   // Pin level view, follows the pins from reset on
   generate
      for (genvar p = 0; p < 2; p++) begin : g_level
         assign pinLevel[p] = pinS[p] ^ (invSel_q[p] & dir_q[p]); // see R06, R08, R13
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclD_q <= 1'b1;
         sdaD_q <= 1'b1;
      end else begin
         sclD_q <= sclS;
         sdaD_q <= sdaS;
      end
   end

   assign sclRise   = sclS & ~sclD_q;
   assign sclFall   = ~sclS & sclD_q;
   assign startDet  = sclS & sclD_q & sdaD_q & ~sdaS;
   assign stopDet   = sclS & sclD_q & ~sdaD_q & sdaS;
   assign byteDone  = sclFall && (bitCnt_q == `BYTE_BITS);
   assign addrMatch = (shift_q[7:1] == {ADDR_UPPER, strapS}); // see R01
   assign cmdDone   = byteDone && (state_q == ST_CMD);
   assign wrCommit  = byteDone && (state_q == ST_WDATA);
   assign mackRise  = sclRise && (state_q == ST_MACK);

   // Bus state machine
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q  <= ST_IDLE; // see R20
         bitCnt_q <= 4'h0;
         shift_q  <= 8'h00;
         rw_q     <= 1'b0;
      end else if (startDet) begin
         state_q  <= ST_ADDR;
         bitCnt_q <= 4'h0;
      end else if (stopDet) begin
         state_q  <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
            end
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (sclRise) begin
                  shift_q  <= {shift_q[6:0], sdaS};
                  bitCnt_q <= bitCnt_q + 4'h1;
               end else if (byteDone) begin
                  bitCnt_q <= 4'h0;
                  if (state_q == ST_ADDR) begin
                     rw_q    <= shift_q[0]; // see R02
                     state_q <= addrMatch ? ST_ADDR_ACK : ST_IDLE;
                  end else if (state_q == ST_CMD) begin
                     state_q <= ST_CMD_ACK;
                  end else begin
                     state_q <= ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (sclFall) begin
                  if (rw_q == `RW_READ) begin // see R02
                     state_q <= ST_RDATA;
                     shift_q <= readByte(ptr_q); // see R04
                  end else begin
                     state_q <= ST_CMD; // see R03
                  end
               end
            end
            ST_CMD_ACK, ST_WDATA_ACK: begin
               if (sclFall) begin
                  state_q <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (sclFall) begin
                  if (bitCnt_q == `LAST_RD_BIT) begin
                     state_q  <= ST_MACK;
                     bitCnt_q <= 4'h0;
                  end else begin
                     shift_q  <= {shift_q[6:0], 1'b0};
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (sclRise) begin
                  rw_q <= sdaS ? 1'b0 : 1'b1;
               end else if (sclFall) begin
                  // A refusal ends the read; the master follows with stop
                  if (rw_q) begin
                     state_q <= ST_RDATA;
                     shift_q <= readByte(ptr_q); // see R18
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Command pointer: loaded by the command byte, walks the pair
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_q <= `PTR_RST;
      end else if (cmdDone) begin
         ptr_q <= shift_q; // see R03
      end else if (wrCommit) begin
         ptr_q[0] <= ~ptr_q[0]; // see R17
      end else if (mackRise) begin
         // Toggled on refusal too, so a later read resumes at the other half
         ptr_q[0] <= ~ptr_q[0]; // see R18
      end
   end

   // Register writes, level pair discards data
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drvLatch_q <= {2{`LATCH_RST}};  // see R09
         invSel_q   <= {2{`INVERT_RST}}; // see R12
         dir_q      <= {2{`DIR_RST}};    // see R14
      end else if (wrCommit) begin // see R07
         if (inPair(ptr_q, `PAIR_LATCH)) begin
            drvLatch_q[ptr_q[0]] <= shift_q; // see R09
         end
         if (inPair(ptr_q, `PAIR_INVERT)) begin
            invSel_q[ptr_q[0]] <= shift_q; // see R12
         end
         if (inPair(ptr_q, `PAIR_DIR)) begin
            dir_q[ptr_q[0]] <= shift_q; // see R14
         end
      end
   end

   // Data line: pulled low for ack, or for a zero data bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sdaOeB <= 1'b1;
      end else begin
         unique case (state_q)
            ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: sdaOeB <= 1'b0;
            ST_RDATA:                              sdaOeB <= shift_q[7];
            default:                               sdaOeB <= 1'b1;
         endcase
      end
   end

   assign sdaOut   = 1'b0;
   assign alertOut = 1'b0;

   // Pins follow latch and direction directly
   assign portAOut = drvLatch_q[0]; // see R10
   assign portBOut = drvLatch_q[1];
   assign portAOeB = dir_q[0]; // see R15
   assign portBOeB = dir_q[1];

   // Clear falls on the acknowledge clock of a port read
   always_comb begin
      readClr = 2'b00;
      if (mackRise && inPair(ptr_q, `PAIR_LEVEL)) begin
         readClr[ptr_q[0]] = 1'b1; // see R19
      end
   end

   generate
      for (genvar p = 0; p < 2; p++) begin : g_alert
         port_alert #(
            .WIDTH (8)
         ) u_alert (
            .clk     (clk),
            .rst_b   (rst_b),
            .level   (pinS[p]),
            .isInput (dir_q[p]),
            .readClr (readClr[p]),
            .alert   (alerts[p])
         );
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alertOeB <= 1'b1;
      end else begin
         alertOeB <= ~|alerts; // see R19
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_addrHit;
      byteDone && state_q == ST_ADDR && addrMatch;
   endsequence

   sequence s_wrLatchA;
      wrCommit && ptr_q[2:0] == `REG_LATCH0;
   endsequence

   sequence s_wrDirA;
      wrCommit && ptr_q[2:0] == `REG_DIR0;
   endsequence

   property p_addrAck;
      s_addrHit |-> ##2 !sdaOeB;
   endproperty
   a_addrAck: assert property (p_addrAck) // see R01
      else $error("address match not acknowledged");

   property p_readSel;
      state_q == ST_ADDR_ACK && sclFall && rw_q |=> state_q == ST_RDATA;
   endproperty
   a_readSel: assert property (p_readSel) // see R02
      else $error("read bit did not start a read");

   property p_ptrLoad;
      cmdDone |=> ptr_q == $past(shift_q);
   endproperty
   a_ptrLoad: assert property (p_ptrLoad) // see R03
      else $error("command byte not stored in pointer");

   property p_levelRo;
      wrCommit && inPair(ptr_q, `PAIR_LEVEL) |=>
         $stable(drvLatch_q) && $stable(invSel_q) && $stable(dir_q);
   endproperty
   a_levelRo: assert property (p_levelRo) // see R07
      else $error("write to level register changed state");

   property p_latchDrive;
      s_wrLatchA |=> portAOut == $past(shift_q);
   endproperty
   a_latchDrive: assert property (p_latchDrive) // see R10
      else $error("latch write not seen on port A");

   property p_dirPins;
      s_wrDirA |=> portAOeB == $past(shift_q);
   endproperty
   a_dirPins: assert property (p_dirPins) // see R15
      else $error("direction write not seen on port A enables");

   property p_invert;
      (invSel_q[0][0] && dir_q[0][0]) |-> pinLevel[0][0] != pinS[0][0];
   endproperty
   a_invert: assert property (p_invert) // see R13
      else $error("inverted input not complemented");

   property p_wrToggle;
      wrCommit |=> ptr_q[0] != $past(ptr_q[0]) && ptr_q[7:1] == $past(ptr_q[7:1]);
   endproperty
   a_wrToggle: assert property (p_wrToggle) // see R17
      else $error("write did not move to the pair partner");

   property p_rdToggle;
      mackRise |=> ptr_q[0] != $past(ptr_q[0]);
   endproperty
   a_rdToggle: assert property (p_rdToggle) // see R18
      else $error("read did not move to the pair partner");

   property p_alertClr;
      readClr[0] && !alerts[1] && $stable(pinS) |-> ##[1:3] alertOeB;
   endproperty
   a_alertClr: assert property (p_alertClr) // see R19
      else $error("alert not released after port read");

   property p_idleFree;
      state_q == ST_IDLE [*2] |-> sdaOeB;
   endproperty
   a_idleFree: assert property (p_idleFree) // see R20
      else $error("data line driven while idle");

endmodule : i2c_gpio_expander

/* tb/i2c_master_model.sv */
module i2c_master_model (
   input  wire logic       clk,       // Bench clock, paces the bus
   input  wire logic       sdaLine,   // Resolved data line
   output logic            sclLine,   // Bus clock, high while idle
   output logic            sdaRel,    // 1 lets the pull-up own the data line
   output logic [7:0]      rxData,    // Last byte read
   output logic            rxToggle   // Flips on each byte read
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sclLine = 1'b1;
      sdaRel = 1'b1;
      rxData = 8'h00;
      rxToggle = 1'b0;
   end

   // Quarters of two clk keep each bus phase at four clk, the slave's minimum
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // Serves as repeated start too, since it first frees the data line
   task automatic start();
      cyc(2);
      sdaRel = 1'b1;
      cyc(2);
      sclLine = 1'b1;
      cyc(4);
      sdaRel = 1'b0;
      cyc(4);
      sclLine = 1'b0;
   endtask : start

   task automatic stop();
      cyc(2);
      sdaRel = 1'b0;
      cyc(2);
      sclLine = 1'b1;
      cyc(4);
      sdaRel = 1'b1;
      cyc(4);
   endtask : stop

   // Sampled mid high phase, well after the slave's late data change
   task automatic bitIo(input logic b, output logic r);
      cyc(2);
      sdaRel = b;
      cyc(2);
      sclLine = 1'b1;
      cyc(2);
      r = sdaLine;
      cyc(2);
      sclLine = 1'b0;
   endtask : bitIo

   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], r);
      end
      bitIo(1'b1, r);
      ack = ~r;
   endtask : sendByte

   // The final byte wanted is not acknowledged
   task automatic recvByte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(1'b1, r);
         d[i] = r;
      end
      bitIo(last, r);
      rxData = d;
      rxToggle = ~rxToggle;
   endtask : recvByte
endmodule : i2c_master_model

/* tb/test_i2c_gpio_expander.sv */
module test_i2c_gpio_expander
   import gpio_exp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] UPPER = 5'h13;  // Arbitrary fixed address bits

   logic        clk, rst_b, sclLine, sdaRel, sdaLine, sdaOut, sdaOeB;
   logic        strapLow, strapHigh, alertOut, alertOeB, rxToggle;
   logic [7:0]  extA, extB, pinA, pinB, rxData;
   logic [7:0]  portAOut, portAOeB, portBOut, portBOeB;
   logic [7:0]  mdl [8];
   logic [7:0]  expQ [$];
   logic [31:0] seed = 32'h0843FE07;
   logic [2:0]  ptr;
   int          n_mismatch, n_tests;

   assign sdaLine = sdaRel & (sdaOeB | sdaOut);
   assign pinA = (portAOeB & extA) | (~portAOeB & portAOut);
   assign pinB = (portBOeB & extB) | (~portBOeB & portBOut);

   i2c_gpio_expander #(.ADDR_UPPER(UPPER)) u_dut (
      .clk(clk), .rst_b(rst_b), .sclPin(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
      .sdaOeB(sdaOeB), .addrStrapLow(strapLow), .addrStrapHigh(strapHigh),
      .portAIn(pinA), .portAOut(portAOut), .portAOeB(portAOeB), .portBIn(pinB),
      .portBOut(portBOut), .portBOeB(portBOeB), .alertOut(alertOut), .alertOeB(alertOeB));

   i2c_master_model u_master (
      .clk(clk), .sdaLine(sdaLine), .sclLine(sclLine), .sdaRel(sdaRel),
      .rxData(rxData), .rxToggle(rxToggle));

   always #10 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Pin level seen by the device, then inverted only where the pin is an input
   function automatic logic [7:0] expReg(input int c);
      logic [7:0] pin;
      if (c > 1) return mdl[c];
      pin = (mdl[6 + c] & (c ? extB : extA)) | (~mdl[6 + c] & mdl[2 + c]);
      return pin ^ (mdl[4 + c] & mdl[6 + c]);
   endfunction : expReg

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   always @(rxToggle) begin
      if ($time > 0) begin
         if (expQ.size() == 0) check(rxData, 8'hXX);
         else check(rxData, expQ.pop_front());
      end
   end

   task automatic resetModel();
      mdl = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
      ptr = 3'h0;
   endtask : resetModel

   task automatic writeRegs(input logic [7:0] cmd, input int n);
      logic       ack;
      logic [7:0] d;
      u_master.start();
      u_master.sendByte({UPPER, strapHigh, strapLow, 1'b0}, ack);
      check({7'h00, ack}, 8'h01);
      u_master.sendByte(cmd, ack);
      ptr = cmd[2:0];
      for (int i = 0; i < n; i++) begin
         d = 8'(rnd());
         u_master.sendByte(d, ack);
         check({7'h00, ack}, 8'h01);
         if (ptr > 1) mdl[ptr] = d;
         ptr[0] = ~ptr[0];
      end
      u_master.stop();
   endtask : writeRegs

   task automatic readRegs(input logic [2:0] cmd, input int n, input logic useCmd);
      logic       ack;
      logic [7:0] d;
      if (useCmd) begin
         u_master.start();
         u_master.sendByte({UPPER, strapHigh, strapLow, 1'b0}, ack);
         u_master.sendByte({5'h00, cmd}, ack);
         ptr = cmd;
      end
      u_master.start();
      u_master.sendByte({UPPER, strapHigh, strapLow, 1'b1}, ack);
      check({7'h00, ack}, 8'h01);
      for (int i = 0; i < n; i++) begin
         expQ.push_back(expReg(ptr));
         u_master.recvByte(i == n - 1, d);
         ptr[0] = ~ptr[0];
      end
      u_master.stop();
   endtask : readRegs

   task automatic readAll(input string name);
      for (int c = 1; c < 8; c += 2) begin
         readRegs(3'(c), 2, 1'b1);
      end
      $display("Test %s done", name);
   endtask : readAll

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run

   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, 8'h00, 8'h01);
      complete_run();
   end

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      {strapHigh, strapLow} = 2'(rnd());
      extA = 8'hA5;
      extB = 8'h3C;
      n_mismatch = 0;
      n_tests = 0;
      resetModel();
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      u_master.cyc(4);
      check(portAOeB & portBOeB, 8'hFF);
      check(portAOut & portBOut, 8'hFF);
      check({5'h00, sdaOut, alertOut, alertOeB}, 8'h01);
      readAll("reset values");
      extB[3] = ~extB[3];
      u_master.cyc(10);
      check({7'h00, alertOeB}, 8'h00);
      extB[3] = ~extB[3];
      u_master.cyc(10);
      check({7'h00, alertOeB}, 8'h01);
      extA[0] = ~extA[0];
      u_master.cyc(10);
      check({7'h00, alertOeB}, 8'h00);
      readRegs(3'h0, 1, 1'b1);
      check({7'h00, alertOeB}, 8'h01);
      $display("Test alert done");
      writeRegs(8'hF3, 3);
      writeRegs(8'h04, 2);
      writeRegs(8'h06, 2);
      extA = 8'(rnd());
      extB = 8'(rnd());
      u_master.cyc(10);
      check(portAOut, mdl[2]);
      check(portBOeB, mdl[7]);
      readAll("configured");
      writeRegs(8'h00, 2);
      writeRegs(8'h05, 2);
      readRegs(3'h0, 2, 1'b0);
      readAll("read only");
      // Walk the straps through all four addresses
      for (int s = 0; s < 3; s++) begin
         {strapHigh, strapLow} = {strapHigh, strapLow} + 2'h1;
         u_master.cyc(4);
         readRegs(3'h6, 2, 1'b1);
      end
      {strapHigh, strapLow} = {strapHigh, strapLow} + 2'h1;
      u_master.cyc(4);
      readAll("straps");
      begin : wrongAddr
         logic ack;
         u_master.start();
         u_master.sendByte({UPPER, ~strapHigh, strapLow, 1'b0}, ack);
         check({7'h00, ack}, 8'h00);
         u_master.stop();
      end
      writeRegs(8'h02, 2);
      writeRegs(8'h06, 2);
      begin : midReset
         logic ack;
         u_master.start();
         u_master.sendByte({UPPER, strapHigh, strapLow, 1'b0}, ack);
         rst_b = 1'b0;
         u_master.cyc(2);
         check(portAOeB & portBOeB & portAOut & portBOut, 8'hFF);
         check({6'h00, sdaOeB, alertOeB}, 8'h03);
         rst_b = 1'b1;
         u_master.cyc(4);
         u_master.stop();
      end
      resetModel();
      readAll("mid reset");
      complete_run();
   end
endmodule : test_i2c_gpio_expander
